// ### hw/irq_mask_params.svh
// Register offsets, field positions, reset values and timing constants of the mask block
// Notes on behaviour
// - Global mask bit 7 unmasks supply-low flag
// - Bits 6,5,4 unmask calibration, charge, voltage
// - Bits 3,2,1 unmask temperature, bus, checksum
// - Bit 0 unmasks read-complete, resets to one
// - Reset release reads memory, flag raises interrupt
// - Output mask bits 5..3 unmask output-low flags
// - Output mask bits 2..0 unmask regulation-good flags
// - Live bit 5 shows calibration busy
// - Live bit 4 shows over-temperature result
// - Live bit 3 shows supply-low result
// - Temperature, supply bits update on periodic samples
// - Live bit 2 valid when third regulator on and standalone
// - Live bit 1 valid when second switcher on
// - Live bit 0 valid when first switcher on
// - Identity: revision bits 7:5, device bits 4:0
// - Sticky flags clear on write one
// - Good flag sets on entering regulation
`ifndef IRQ_MASK_PARAMS_SVH
`define IRQ_MASK_PARAMS_SVH

`define OFS_GLOBAL_FLAGS 8'h00
`define OFS_OUTPUT_FLAGS 8'h01
`define OFS_GLOBAL_MASK 8'h02
`define OFS_OUTPUT_MASK 8'h03
`define OFS_LIVE_VIEW 8'h04
`define OFS_IDENTITY 8'h05
`define OFS_SAMPLE_PERIOD 8'h06

`define RST_GLOBAL_MASK 8'h01
`define RST_OUTPUT_MASK 6'h00
`define OUT_MASK_USED 8'h3f

`define GBIT_SUPPLY_LOW 7
`define GBIT_CAL_DONE 6
`define GBIT_CHARGE_OVER 5
`define GBIT_VOLT_FAULT 4
`define GBIT_TEMP_FAULT 3
`define GBIT_BUS_FAULT 2
`define GBIT_CRC_FAULT 1
`define GBIT_READ_DONE 0

`define LBIT_CAL_BUSY 5
`define LBIT_OVER_TEMP 4
`define LBIT_SUPPLY_LOW 3

// Arbitrary neutral identity values
`define REVISION_CODE 3'h2
`define DEVICE_CODE 5'h0a

// Memory read after reset release, in ns and in 8 ns cycles
`define MEM_READ_NS 80
`define MEM_READ_CYCLES ((`MEM_READ_NS + 7) / 8)

`endif

// ### hw/irq_mask_pkg.sv
// Types shared by the mask block
package irq_mask_pkg;
	typedef enum logic [1:0] {
		BOOT_IDLE,
		BOOT_READ,
		BOOT_DONE
	} boot_state_e;
	typedef logic [7:0] reg_byte_t;
endpackage

// ### hw/sticky_flags.sv
// Sticky event flags with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
module sticky_flags #(
	parameter int WIDTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic [WIDTH-1:0] i_set,
	input wire logic [WIDTH-1:0] i_clear,
	output logic [WIDTH-1:0] o_flags
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_flag
			always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					o_flags[g] <= 1'b0;
				end else if (i_set[g]) begin
					o_flags[g] <= 1'b1;
				end else if (i_clear[g]) begin
					o_flags[g] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule

// ### hw/pmic_irq_mask_live_status.sv
// Interrupt masks, sticky flags, live condition view and identity register
`timescale 1ns/1ps
`include "irq_mask_params.svh"
module pmic_irq_mask_live_status (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_supply_low_evt,
	input wire logic i_cal_done_evt,
	input wire logic i_charge_over_evt,
	input wire logic i_voltage_fault_evt,
	input wire logic i_temp_fault_evt,
	input wire logic i_bus_fault_evt,
	input wire logic i_crc_fault_evt,
	input wire logic [2:0] i_out_low_evt,
	input wire logic [2:0] i_out_in_reg,
	input wire logic i_first_switcher_en,
	input wire logic i_second_switcher_en,
	input wire logic i_third_linear_regulator_en,
	input wire logic i_third_paralleled,
	input wire logic i_cal_busy,
	input wire logic i_over_temp_cmp,
	input wire logic i_supply_low_cmp,
	output logic o_irq,
	output logic o_converter_sample_tick
);
	irq_mask_pkg::reg_byte_t global_mask_q;
	logic [5:0] output_mask_q;
	irq_mask_pkg::reg_byte_t sample_period_q;
	irq_mask_pkg::reg_byte_t sample_cnt_q;
	logic over_temp_now_q;
	logic supply_low_now_q;
	logic [2:0] in_reg_prev_q;
	logic [3:0] boot_cnt_q;
	logic boot_done_pulse_q;
	irq_mask_pkg::boot_state_e boot_q;
	irq_mask_pkg::boot_state_e boot_d;
	logic irq_q;
	logic tick_q;
	irq_mask_pkg::reg_byte_t rdata_q;
	logic [7:0] global_flags;
	logic [5:0] output_flags;

	wire hit_gflags = i_addr == `OFS_GLOBAL_FLAGS;
	wire hit_oflags = i_addr == `OFS_OUTPUT_FLAGS;
	wire hit_gmask = i_addr == `OFS_GLOBAL_MASK;
	wire hit_omask = i_addr == `OFS_OUTPUT_MASK;
	wire hit_live = i_addr == `OFS_LIVE_VIEW;
	wire hit_ident = i_addr == `OFS_IDENTITY;
	wire hit_period = i_addr == `OFS_SAMPLE_PERIOD;

	// Converter samples only when a non-zero period is programmed
	wire sample_now = (sample_period_q != 8'h00) && (sample_cnt_q == 8'h00);

	// Validity gating per output
	wire out1_valid = i_first_switcher_en;
	wire out2_valid = i_second_switcher_en;
	wire out3_valid = i_third_linear_regulator_en && !i_third_paralleled;
	wire [2:0] out_valid = {out3_valid, out2_valid, out1_valid};
	wire [2:0] out_regulating_now = i_out_in_reg & out_valid;

	wire [7:0] live_condition_view = {2'b00, i_cal_busy, over_temp_now_q, supply_low_now_q,
		out_regulating_now};
	wire [7:0] chip_identity = {`REVISION_CODE, `DEVICE_CODE};

	// Regulation-good sets only on a valid low-to-high transition
	wire [2:0] good_rise = out_regulating_now & ~in_reg_prev_q;

	wire [7:0] gset = {i_supply_low_evt, i_cal_done_evt, i_charge_over_evt,
		i_voltage_fault_evt, i_temp_fault_evt, i_bus_fault_evt, i_crc_fault_evt,
		boot_done_pulse_q};
	wire [5:0] oset = {i_out_low_evt, good_rise};
	wire [7:0] gclr = (i_wr && hit_gflags) ? i_wdata : 8'h00;
	wire [5:0] oclr = (i_wr && hit_oflags) ? i_wdata[5:0] : 6'h00;

	wire irq_d = |(global_flags & global_mask_q) | |(output_flags & output_mask_q);

	wire [7:0] rdata_d = hit_gflags ? global_flags :
		hit_oflags ? {2'b00, output_flags} :
		hit_gmask ? global_mask_q :
		hit_omask ? {2'b00, output_mask_q} :
		hit_live ? live_condition_view :
		hit_ident ? chip_identity :
		hit_period ? sample_period_q : 8'h00;

	sticky_flags #(.WIDTH(8)) u_global_flags (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_set(gset),
		.i_clear(gclr),
		.o_flags(global_flags)
	);

	sticky_flags #(.WIDTH(6)) u_output_flags (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_set(oset),
		.i_clear(oclr),
		.o_flags(output_flags)
	);

	// Boot sequencer models the memory read that follows reset release
	always_comb begin
		boot_d = boot_q;
		unique case (boot_q)
			irq_mask_pkg::BOOT_IDLE: boot_d = irq_mask_pkg::BOOT_READ;
			irq_mask_pkg::BOOT_READ: begin
				if (boot_cnt_q == 4'(`MEM_READ_CYCLES - 1)) begin
					boot_d = irq_mask_pkg::BOOT_DONE;
				end
			end
			irq_mask_pkg::BOOT_DONE: boot_d = irq_mask_pkg::BOOT_DONE;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			boot_q <= irq_mask_pkg::BOOT_IDLE;
			boot_cnt_q <= 4'h0;
			boot_done_pulse_q <= 1'b0;
		end else begin
			boot_q <= boot_d;
			boot_cnt_q <= (boot_q == irq_mask_pkg::BOOT_READ) ? boot_cnt_q + 4'h1 : 4'h0;
			boot_done_pulse_q <= (boot_q == irq_mask_pkg::BOOT_READ) &&
				(boot_d == irq_mask_pkg::BOOT_DONE);
		end
	end

	// Mask registers; reserved output-mask bits are not stored
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			global_mask_q <= `RST_GLOBAL_MASK;
			output_mask_q <= `RST_OUTPUT_MASK;
			sample_period_q <= 8'h00;
		end else if (i_wr) begin
			if (hit_gmask) begin
				global_mask_q <= i_wdata;
			end
			if (hit_omask) begin
				output_mask_q <= i_wdata[5:0];
			end
			if (hit_period) begin
				sample_period_q <= i_wdata;
			end
		end
	end

	// Temperature and supply levels only move on a converter sample
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sample_cnt_q <= 8'h00;
			over_temp_now_q <= 1'b0;
			supply_low_now_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			sample_cnt_q <= sample_now ? sample_period_q : 
				(sample_cnt_q != 8'h00 ? sample_cnt_q - 8'h01 : 8'h00);
			tick_q <= sample_now;
			if (sample_now) begin
				over_temp_now_q <= i_over_temp_cmp;
				supply_low_now_q <= i_supply_low_cmp;
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			in_reg_prev_q <= 3'h0;
			irq_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			in_reg_prev_q <= out_regulating_now;
			irq_q <= irq_d;
			rdata_q <= i_rd ? rdata_d : 8'h00;
		end
	end

	assign o_irq = irq_q;
	assign o_rdata = rdata_q;
	assign o_converter_sample_tick = tick_q;

	a_mask_reset_value: assert property (@(posedge i_sys_clk)
		$fell(i_sys_rst) |-> global_mask_q == 8'h01 && output_mask_q == 6'h00)
		else $error("mask reset value wrong");

	a_boot_irq_raise: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		boot_done_pulse_q && global_mask_q[0] |=> global_flags[0] ##1 o_irq)
		else $error("read-complete did not raise interrupt");

	a_irq_follows_pairs: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(|(global_flags & global_mask_q) || |(output_flags & output_mask_q)) |=> o_irq)
		else $error("interrupt missed unmasked flag");

	a_irq_quiet: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!(|(global_flags & global_mask_q)) && !(|(output_flags & output_mask_q)) |=> !o_irq)
		else $error("interrupt without unmasked flag");

	a_set_beats_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		gset[7] && gclr[7] |=> global_flags[7])
		else $error("set lost to clear");

	a_clear_on_one: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		i_wr && hit_oflags && i_wdata[0] && !oset[0] |=> !output_flags[0])
		else $error("write one did not clear");

	a_good_rise_set: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		i_first_switcher_en && $rose(i_out_in_reg[0]) && $past(i_first_switcher_en)
		|=> output_flags[0])
		else $error("good flag not set");

	a_third_gated: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		i_rd && hit_live && i_third_paralleled |=> !o_rdata[2])
		else $error("paralleled third output shown in regulation");

	a_live_temp_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		sample_period_q == 8'h00 |=> $stable(over_temp_now_q) && $stable(supply_low_now_q))
		else $error("live level moved without sampling");

	a_ident_read: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		i_rd && hit_ident |=> o_rdata == {`REVISION_CODE, `DEVICE_CODE})
		else $error("identity read wrong");

	a_cal_busy_read: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		i_rd && hit_live |=> o_rdata[7:5] == {2'b00, $past(i_cal_busy)})
		else $error("calibration busy bit wrong");

	// Read data lags its strobe by one cycle, hence the next-cycle forms
	a_gmask_write: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_wr && hit_gmask |=> global_mask_q == $past(i_wdata))
		else $error("global mask write lost");

	a_omask_write: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_wr && hit_omask |=> output_mask_q == $past(i_wdata[5:0]))
		else $error("output mask write lost");

	a_gmask_read: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_rd && hit_gmask |=> o_rdata == $past(global_mask_q))
		else $error("global mask read wrong");

	a_omask_read: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_rd && hit_omask |=> o_rdata == {2'b00, $past(output_mask_q)})
		else $error("output mask read wrong");

	// Eleven edges: ten read cycles, then the state change raises the pulse
	a_boot_done_time: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) $fell(i_sys_rst) |-> ##11 boot_done_pulse_q)
		else $error("memory read did not complete in time");

	a_boot_single: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) boot_done_pulse_q |=> !boot_done_pulse_q)
		else $error("read-complete pulse repeated");

	a_tick_single: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) o_converter_sample_tick |=> !o_converter_sample_tick)
		else $error("sample tick longer than one cycle");

	a_tick_needs_period: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) sample_period_q == 8'h00 |=> !o_converter_sample_tick)
		else $error("sample tick without period");

	a_live_capture: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) o_converter_sample_tick |->
		over_temp_now_q == $past(i_over_temp_cmp) &&
		supply_low_now_q == $past(i_supply_low_cmp))
		else $error("live level not captured on sample");

	a_live_reset: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) $fell(i_sys_rst) |-> !over_temp_now_q && !supply_low_now_q)
		else $error("live level not cleared by reset");

	a_out1_gated: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_rd && hit_live && !i_first_switcher_en |=> !o_rdata[0])
		else $error("disabled first output shown in regulation");

	a_out2_gated: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_rd && hit_live && !i_second_switcher_en |=> !o_rdata[1])
		else $error("disabled second output shown in regulation");

	a_out1_shown: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_rd && hit_live && i_first_switcher_en |=>
		o_rdata[0] == $past(i_out_in_reg[0]))
		else $error("first output regulation bit wrong");

	a_out2_shown: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_rd && hit_live && i_second_switcher_en |=>
		o_rdata[1] == $past(i_out_in_reg[1]))
		else $error("second output regulation bit wrong");

	a_out3_shown: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_rd && hit_live && i_third_linear_regulator_en &&
		!i_third_paralleled |=> o_rdata[2] == $past(i_out_in_reg[2]))
		else $error("third output regulation bit wrong");

	a_good_gated: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) !i_first_switcher_en && !output_flags[0] |=> !output_flags[0])
		else $error("good flag set on disabled output");

	a_clear_global: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) i_wr && hit_gflags && i_wdata[7] && !gset[7] |=>
		!global_flags[7])
		else $error("global flag not cleared by one");

	a_flag_sticky: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst) global_flags[3] && !gclr[3] |=> global_flags[3])
		else $error("flag dropped without clear");
endmodule

// ### tb/host_model.sv
// Host side register bus master with write and read tasks
`timescale 1ns/1ps
module host_model (
	input wire logic i_sys_clk,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	input wire logic [7:0] i_rdata
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == 8'h02) begin
			v[0] = 1'b1;
		end
		if (a == 8'h03 || a == 8'h04) begin
			v[7:6] = 2'h0;
		end
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wdata <= v;
		o_wr <= 1'b1;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_wdata <= ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_sys_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask
endmodule

// ### tb/pmic_irq_mask_live_status_bench.sv
// Self-checking bench of the mask, live view and identity block
`timescale 1ns/1ps
module pmic_irq_mask_live_status_bench;
	logic clk = 1'b0, rst = 1'b1, wr, rd, irq, tick;
	logic [7:0] addr, wdata, rdata;
	logic [7:1] ev = 7'h00;
	logic [2:0] olow = 3'h0, inreg = 3'h0;
	logic en1 = 1'b0, en2 = 1'b0, en3 = 1'b0, par = 1'b0;
	logic busy = 1'b0, ot = 1'b0, sl = 1'b0;
	int num_errors = 0, num_checks = 0;
	always #4 clk = ~clk;
	host_model host_model_i (.i_sys_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
		.o_rd(rd), .i_rdata(rdata));
	pmic_irq_mask_live_status pmic_irq_mask_live_status_i (.i_sys_clk(clk), .i_sys_rst(rst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_supply_low_evt(ev[7]), .i_cal_done_evt(ev[6]), .i_charge_over_evt(ev[5]),
		.i_voltage_fault_evt(ev[4]), .i_temp_fault_evt(ev[3]), .i_bus_fault_evt(ev[2]),
		.i_crc_fault_evt(ev[1]), .i_out_low_evt(olow), .i_out_in_reg(inreg),
		.i_first_switcher_en(en1), .i_second_switcher_en(en2),
		.i_third_linear_regulator_en(en3), .i_third_paralleled(par), .i_cal_busy(busy),
		.i_over_temp_cmp(ot), .i_supply_low_cmp(sl), .o_irq(irq),
		.o_converter_sample_tick(tick));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_model_i.rd(a, d);
		chk(n, e, d);
	endtask
	task automatic irq_after(input int n, input logic e);
		repeat (n) @(posedge clk);
		#1 chk("irq", {7'h0, e}, {7'h0, irq});
	endtask
	task automatic ticks_in_twelve(input logic [7:0] e);
		int n;
		n = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (tick !== 1'b0) begin
				n++;
			end
		end
		chk("sample_ticks", e, 8'(n));
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic reset_and_boot;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		irq_after(20, 1'b1);
		rdc("global_flags", 8'h00, 8'h01);
		host_model_i.wr(8'h00, 8'h01);
		irq_after(2, 1'b0);
		rdc("global_mask", 8'h02, 8'h01);
		rdc("output_mask", 8'h03, 8'h00);
		rdc("live_view", 8'h04, 8'h00);
		rdc("identity", 8'h05, 8'h4a);
		rdc("unmapped", 8'h7f, 8'h00);
	endtask
	task automatic global_events;
		for (int b = 1; b < 8; b++) begin
			host_model_i.wr(8'h02, 8'h01 << b);
			rdc("global_mask", 8'h02, (8'h01 << b) | 8'h01);
			@(posedge clk) ev[b] <= 1'b1;
			@(posedge clk) ev[b] <= 1'b0;
			irq_after(2, 1'b1);
			host_model_i.wr(8'h00, 8'h01 << b);
			irq_after(2, 1'b0);
		end
		host_model_i.wr(8'h02, 8'h00);
		@(posedge clk) ev[7] <= 1'b1;
		@(posedge clk) ev[7] <= 1'b0;
		irq_after(3, 1'b0);
		rdc("global_flags", 8'h00, 8'h80);
		host_model_i.wr(8'h00, 8'h80);
		fork
			host_model_i.wr(8'h00, 8'h80);
			begin
				@(posedge clk) ev[7] <= 1'b1;
				@(posedge clk) ev[7] <= 1'b0;
			end
		join
		rdc("global_flags", 8'h00, 8'h80);
		host_model_i.wr(8'h00, 8'h80);
		rdc("global_flags", 8'h00, 8'h00);
	endtask
	task automatic output_events;
		host_model_i.wr(8'h03, 8'hff);
		rdc("output_mask", 8'h03, 8'h3f);
		@(posedge clk) olow <= 3'h7;
		@(posedge clk) olow <= 3'h0;
		irq_after(2, 1'b1);
		rdc("output_flags", 8'h01, 8'h38);
		host_model_i.wr(8'h01, 8'h38);
		irq_after(2, 1'b0);
		@(posedge clk) {en1, en2, en3} <= 3'h7;
		@(posedge clk) inreg <= 3'h7;
		irq_after(4, 1'b1);
		rdc("output_flags", 8'h01, 8'h07);
		host_model_i.wr(8'h01, 8'h07);
		host_model_i.wr(8'h03, 8'h00);
		irq_after(2, 1'b0);
	endtask
	task automatic live_view;
		@(posedge clk) busy <= 1'b1;
		rdc("live_view", 8'h04, 8'h27);
		@(posedge clk) par <= 1'b1;
		rdc("live_view", 8'h04, 8'h23);
		@(posedge clk) en2 <= 1'b0;
		rdc("live_view", 8'h04, 8'h21);
		@(posedge clk) {ot, sl} <= 2'h3;
		repeat (10) @(posedge clk);
		rdc("live_view", 8'h04, 8'h21);
		host_model_i.wr(8'h06, 8'h03);
		repeat (10) @(posedge clk);
		rdc("live_view", 8'h04, 8'h39);
		ticks_in_twelve(8'h03);
		host_model_i.wr(8'h06, 8'h00);
		ticks_in_twelve(8'h00);
	endtask
	task automatic mid_reset;
		host_model_i.wr(8'h02, 8'hfe);
		@(posedge clk) rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		irq_after(20, 1'b1);
		rdc("global_mask", 8'h02, 8'h01);
		rdc("global_flags", 8'h00, 8'h01);
		host_model_i.wr(8'h00, 8'h01);
		irq_after(2, 1'b0);
	endtask
	initial begin
		reset_and_boot();
		global_events();
		output_events();
		live_view();
		mid_reset();
		test_done();
	end
	initial begin
		#40000;
		num_errors++;
		test_done();
	end
endmodule
